// >>> scsi_target_pkg.sv
// Package for the target-role SCSI sequencer.
// Assumes one core clock; register offsets, field layout and codes live here.
package scsi_target_pkg;

  // ****************************************
  // Register offsets (plain register port)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_AUX = 4'h2;
  localparam logic [3:0] ADDR_INT = 4'h3;
  localparam logic [3:0] ADDR_SRC_ID = 4'h4;
  localparam logic [3:0] ADDR_DST_ID = 4'h5;
  localparam logic [3:0] ADDR_TC_HI = 4'h6;
  localparam logic [3:0] ADDR_TC_MID = 4'h7;
  localparam logic [3:0] ADDR_TC_LO = 4'h8;

  // ****************************************
  // Command register layout and opcodes
  // ****************************************
  localparam int CMD_SBT_BIT = 7;
  localparam int CMD_DMA_BIT = 6;
  localparam logic [4:0] OP_CHIP_RESET = 5'h00;
  localparam logic [4:0] OP_DISCONNECT = 5'h01;
  localparam logic [4:0] OP_PAUSE = 5'h02;
  localparam logic [4:0] OP_RESELECT = 5'h05;
  localparam logic [4:0] OP_RECV_CMD = 5'h10;
  localparam logic [4:0] OP_RECV_DATA = 5'h11;
  localparam logic [4:0] OP_RECV_MSG_OUT = 5'h12;
  localparam logic [4:0] OP_SEND_STATUS = 5'h14;
  localparam logic [4:0] OP_SEND_DATA = 5'h15;
  localparam logic [4:0] OP_SEND_MSG_IN = 5'h16;

  // ****************************************
  // Interrupt register codes
  // ****************************************
  localparam logic [7:0] INT_FUNC_DONE = 8'h01;
  localparam logic [7:0] INT_BUS_SVC = 8'h02;
  localparam logic [7:0] INT_TIMEOUT = 8'h04;
  localparam logic [7:0] INT_SELECTED = 8'h08;
  localparam logic [7:0] INT_RESELECTED = 8'h10;
  localparam logic [7:0] INT_INVALID = 8'h40;

  // ****************************************
  // Auxiliary status bit positions
  // ****************************************
  localparam int AUX_FULL_BIT = 7;
  localparam int AUX_BUSY_BIT = 5;
  localparam int AUX_PHASE_LSB = 2;
  localparam int AUX_TC_ZERO_BIT = 1;
  localparam int AUX_IRQ_BIT = 0;
  localparam int SRC_VALID_BIT = 7;

  // ****************************************
  // Phase codes {msg, cd, io} and reset values
  // ****************************************
  localparam logic [2:0] PH_DATA_OUT = 3'b000;
  localparam logic [2:0] PH_DATA_IN = 3'b001;
  localparam logic [2:0] PH_COMMAND = 3'b010;
  localparam logic [2:0] PH_STATUS = 3'b011;
  localparam logic [2:0] PH_MSG_OUT = 3'b110;
  localparam logic [2:0] PH_MSG_IN = 3'b111;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [23:0] TC_RESET = 24'h000000;
  localparam int SYNC_STAGES = 3;

  // ****************************************
  // Pin groups
  // ****************************************
  typedef struct packed {
    logic bsy;
    logic sel;
    logic atn;
    logic ack;
    logic [7:0] data;
  } scsi_in_type;

  typedef struct packed {
    logic bsy;
    logic sel;
    logic req;
    logic msg;
    logic cd;
    logic io;
    logic [7:0] data;
  } scsi_out_type;

endpackage : scsi_target_pkg

// >>> pin_sync.sv
// Three-stage synchroniser for a group of pins.
// Assumes inputs are asynchronous to core_clk; output moves when stages two and three agree.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  // Per bit, a change counts only once the late stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  // Stage one is read only by stage two
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;

endmodule : pin_sync

// >>> scsi_target_role_sequencer.sv
// Target-role command and interrupt sequencer of a SCSI protocol controller.
// Assumes a local host on a plain register port and a DMA engine on a req/ack pair.
// Overview of operation
// - While target, drive C/D, I/O and MSG for every information phase.
// - Selected with ATN: report selected plus bus service, then connected.
// - Single-byte message out sets data-register-full; host polls it first.
// - Source ID register holds initiator ID and its disconnect-capable bit.
// - Operation-complete fires as the message byte sets full, before the host reads it.
// - Message in: host writes byte when full is clear; device sends, completes.
// - Disconnect command, unless already disconnected (then it raises invalid), acts at once, no interrupt, device becomes disconnected.
// - Successful reselection raises operation-complete and connects as target.
// - Receive/send command with DMA moves counter bytes, then completes.
// - Send status runs single-byte without DMA, completes after sending.
// - Loading an interrupting command clears data-register-full.
// - Interrupt read clears register, output and busy; bus event beats interrupting command.
// - Target send or receive completion reads as interrupt code 0x01, or 0x03 while ATN is asserted.
// - Selection with ATN reads as interrupt code 0x0a.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module scsi_target_role_sequencer
  import scsi_target_pkg::*;
#(
  parameter logic [2:0] OWN_ID = 3'h7
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic dma_req,
  input wire logic dma_ack,
  input wire logic [7:0] dma_rdata,
  output logic [7:0] dma_wdata,
  input wire scsi_in_type scsi_i,
  output scsi_out_type scsi_o,
  output scsi_out_type scsi_oe
);

  // ****************************************
  // State and storage
  // ****************************************
  typedef enum logic [3:0] {
    st_disc, st_sel_hold, st_conn, st_fetch, st_req, st_ack_low, st_deliver,
    st_resel_wait
  } state_type;

  state_type state_q, state_d;
  scsi_in_type bus_s;
  logic [7:0] data_q, data_d, int_q, int_d, rdata_q, rdata_d;
  logic [7:0] in_byte_q, in_byte_d, dout_q, dout_d;
  logic [23:0] tc_q, tc_d, timer_q, timer_d;
  logic [2:0] src_id_q, src_id_d, dst_id_q, dst_id_d, phase_q, phase_d;
  logic full_q, full_d, detach_q, detach_d, busy_q, busy_d;
  logic recv_q, recv_d, sbt_q, sbt_d, dma_q, dma_d;
  logic bsy_q, bsy_d, sel_q, sel_d, req_q, req_d, dout_oe_q, dout_oe_d;
  logic atn_prev_q, atn_prev_d;
  logic cmd_wr, bus_event, byte_done, other_seen, full_set;
  logic [2:0] other_id;
  logic [4:0] op;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_sync #(.WIDTH($bits(scsi_in_type))) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(scsi_i),
    .pin_out(bus_s)
  );

  // Initiator ID is the data bit other than our own during selection
  always_comb begin
    other_id = 3'h0;
    other_seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (bus_s.data[i] && (i[2:0] != OWN_ID)) begin
        other_id = i[2:0];
        other_seen = 1'b1;
      end
    end
  end

  assign cmd_wr = reg_wr && (reg_addr == ADDR_CMD);
  assign op = reg_wdata[4:0];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_d = state_q;
    data_d = data_q;
    int_d = int_q;
    in_byte_d = in_byte_q;
    dout_d = dout_q;
    tc_d = tc_q;
    timer_d = timer_q;
    src_id_d = src_id_q;
    dst_id_d = dst_id_q;
    phase_d = phase_q;
    full_d = full_q;
    detach_d = detach_q;
    busy_d = busy_q;
    recv_d = recv_q;
    sbt_d = sbt_q;
    dma_d = dma_q;
    bsy_d = bsy_q;
    sel_d = sel_q;
    req_d = req_q;
    dout_oe_d = dout_oe_q;
    atn_prev_d = bus_s.atn;
    bus_event = 1'b0;
    byte_done = 1'b0;
    full_set = 1'b0;
    dma_req = 1'b0;
    rdata_d = BYTE_RESET;

    // Host register reads; read data stands one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_DATA: rdata_d = data_q;
        ADDR_AUX: rdata_d = {full_q, 1'b0, busy_q, phase_q, (tc_q == TC_RESET), irq};
        ADDR_INT: rdata_d = int_q;
        ADDR_SRC_ID: rdata_d = {detach_q, 4'h0, src_id_q};
        ADDR_DST_ID: rdata_d = {5'h00, dst_id_q};
        ADDR_TC_HI: rdata_d = tc_q[23:16];
        ADDR_TC_MID: rdata_d = tc_q[15:8];
        ADDR_TC_LO: rdata_d = tc_q[7:0];
        default: rdata_d = BYTE_RESET;
      endcase
    end
    if (reg_rd && (reg_addr == ADDR_INT)) begin
      int_d = BYTE_RESET;
      busy_d = 1'b0;
    end
    if (reg_rd && (reg_addr == ADDR_DATA)) begin
      full_d = 1'b0;
    end

    // Host register writes other than commands
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_DATA: begin
          data_d = reg_wdata;
          full_d = 1'b1;
        end
        ADDR_DST_ID: dst_id_d = reg_wdata[2:0];
        ADDR_TC_HI: tc_d[23:16] = reg_wdata;
        ADDR_TC_MID: tc_d[15:8] = reg_wdata;
        ADDR_TC_LO: tc_d[7:0] = reg_wdata;
        default: ;
      endcase
    end

    // Bus sequencing
    unique case (state_q)
      st_disc: begin
        if (bus_s.sel && !bus_s.bsy && bus_s.data[OWN_ID]) begin
          src_id_d = other_id;
          detach_d = other_seen && bus_s.atn;
          bsy_d = 1'b1;
          bus_event = 1'b1;
          state_d = st_sel_hold;
        end
      end
      st_sel_hold: begin
        if (!bus_s.sel) begin
          int_d = int_d | INT_SELECTED | (bus_s.atn ? INT_BUS_SVC : BYTE_RESET);
          phase_d = bus_s.atn ? PH_MSG_OUT : PH_COMMAND;
          state_d = st_conn;
        end
      end
      st_conn: begin
        if (bus_s.atn && !atn_prev_q) begin
          int_d = int_d | INT_BUS_SVC;
          bus_event = 1'b1;
        end
      end
      st_fetch: begin
        if (!dma_q) begin
          if (full_q) begin
            dout_d = data_q;
            full_d = 1'b0;
            dout_oe_d = 1'b1;
            req_d = 1'b1;
            state_d = st_req;
          end
        end else begin
          dma_req = 1'b1;
          if (dma_ack) begin
            dout_d = dma_rdata;
            dout_oe_d = 1'b1;
            req_d = 1'b1;
            state_d = st_req;
          end
        end
      end
      st_req: begin
        // Wait for the initiator to take or give the byte
        if (bus_s.ack) begin
          if (recv_q) begin
            in_byte_d = bus_s.data;
          end
          req_d = 1'b0;
          state_d = st_ack_low;
        end
      end
      st_ack_low: begin
        if (!bus_s.ack) begin
          dout_oe_d = 1'b0;
          if (recv_q) begin
            state_d = st_deliver;
          end else begin
            byte_done = 1'b1;
          end
        end
      end
      st_deliver: begin
        if (!dma_q) begin
          if (!full_q) begin
            data_d = in_byte_q;
            full_d = 1'b1;
            full_set = 1'b1;
            byte_done = 1'b1;
          end
        end else begin
          dma_req = 1'b1;
          if (dma_ack) begin
            byte_done = 1'b1;
          end
        end
      end
      st_resel_wait: begin
        if (bus_s.bsy) begin
          bsy_d = 1'b1;
          sel_d = 1'b0;
          dout_oe_d = 1'b0;
          int_d = int_d | INT_FUNC_DONE;
          state_d = st_conn;
        end else if (timer_q == TC_RESET) begin
          sel_d = 1'b0;
          dout_oe_d = 1'b0;
          int_d = int_d | INT_TIMEOUT;
          state_d = st_disc;
        end else begin
          timer_d = timer_q - 24'h000001;
        end
      end
      default: state_d = st_disc;
    endcase

    // Count bytes, complete at the end
    if (byte_done) begin
      tc_d = (tc_q == TC_RESET) ? TC_RESET : tc_q - 24'h000001;
      if (sbt_q || (tc_d == TC_RESET)) begin
        int_d = int_d | INT_FUNC_DONE | (bus_s.atn ? INT_BUS_SVC : BYTE_RESET);
        state_d = st_conn;
      end else begin
        req_d = recv_q;
        state_d = recv_q ? st_req : st_fetch;
      end
    end

    // Command decode; a bus event in the same cycle wins over interrupting commands only
    if (cmd_wr && (op == OP_CHIP_RESET)) begin
      state_d = st_disc;
      int_d = BYTE_RESET;
      full_d = 1'b0;
      busy_d = 1'b0;
      bsy_d = 1'b0;
      sel_d = 1'b0;
      req_d = 1'b0;
      dout_oe_d = 1'b0;
      phase_d = PH_DATA_OUT;
    end else if (cmd_wr && (op == OP_PAUSE)) begin
      busy_d = busy_q;
    end else if (cmd_wr && (op == OP_DISCONNECT) && (state_q != st_disc)) begin
      state_d = st_disc;
      bsy_d = 1'b0;
      sel_d = 1'b0;
      req_d = 1'b0;
      dout_oe_d = 1'b0;
      phase_d = PH_DATA_OUT;
    end else if (cmd_wr && !bus_event) begin
      // interrupting command empties data register
      // A byte landing in this same cycle still wins
      full_d = full_set;
      busy_d = 1'b1;
      if ((state_q == st_disc) && (op == OP_RESELECT)) begin
        sel_d = 1'b1;
        phase_d = PH_DATA_IN;
        dout_d = 8'h01 << OWN_ID | 8'h01 << dst_id_q;
        dout_oe_d = 1'b1;
        timer_d = tc_q;
        state_d = st_resel_wait;
      end else if ((state_q == st_conn) && (op >= OP_RECV_CMD) && (op <= OP_SEND_MSG_IN) &&
                   (op != 5'h13)) begin
        recv_d = (op < OP_SEND_STATUS);
        sbt_d = reg_wdata[CMD_SBT_BIT] || (op == OP_SEND_STATUS);
        dma_d = reg_wdata[CMD_DMA_BIT] && (op != OP_SEND_STATUS);
        req_d = (op < OP_SEND_STATUS);
        state_d = (op < OP_SEND_STATUS) ? st_req : st_fetch;
        unique case (op)
          OP_RECV_CMD: phase_d = PH_COMMAND;
          OP_RECV_DATA: phase_d = PH_DATA_OUT;
          OP_RECV_MSG_OUT: phase_d = PH_MSG_OUT;
          OP_SEND_STATUS: phase_d = PH_STATUS;
          OP_SEND_DATA: phase_d = PH_DATA_IN;
          default: phase_d = PH_MSG_IN;
        endcase
      end else begin
        int_d = int_d | INT_INVALID;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_disc;
      data_q <= BYTE_RESET;
      int_q <= BYTE_RESET;
      rdata_q <= BYTE_RESET;
      in_byte_q <= BYTE_RESET;
      dout_q <= BYTE_RESET;
      tc_q <= TC_RESET;
      timer_q <= TC_RESET;
      src_id_q <= 3'h0;
      dst_id_q <= 3'h0;
      phase_q <= PH_DATA_OUT;
      full_q <= 1'b0;
      detach_q <= 1'b0;
      busy_q <= 1'b0;
      recv_q <= 1'b0;
      sbt_q <= 1'b0;
      dma_q <= 1'b0;
      bsy_q <= 1'b0;
      sel_q <= 1'b0;
      req_q <= 1'b0;
      dout_oe_q <= 1'b0;
      atn_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      data_q <= data_d;
      int_q <= int_d;
      rdata_q <= rdata_d;
      in_byte_q <= in_byte_d;
      dout_q <= dout_d;
      tc_q <= tc_d;
      timer_q <= timer_d;
      src_id_q <= src_id_d;
      dst_id_q <= dst_id_d;
      phase_q <= phase_d;
      full_q <= full_d;
      detach_q <= detach_d;
      busy_q <= busy_d;
      recv_q <= recv_d;
      sbt_q <= sbt_d;
      dma_q <= dma_d;
      bsy_q <= bsy_d;
      sel_q <= sel_d;
      req_q <= req_d;
      dout_oe_q <= dout_oe_d;
      atn_prev_q <= atn_prev_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Phase lines driven while we hold BSY as target; I/O also while SEL is held for reselection
  assign scsi_o = '{bsy: bsy_q, sel: sel_q, req: req_q, msg: phase_q[2] & bsy_q,
                    cd: phase_q[1] & bsy_q, io: phase_q[0] & (bsy_q | sel_q), data: dout_q};
  assign scsi_oe = '{bsy: bsy_q, sel: sel_q, req: req_q, msg: phase_q[2] & bsy_q,
                     cd: phase_q[1] & bsy_q, io: phase_q[0] & (bsy_q | sel_q),
                     data: {8{dout_oe_q}}};
  assign reg_rdata = rdata_q;
  assign irq = |int_q;
  assign dma_wdata = in_byte_q;

endmodule : scsi_target_role_sequencer

// >>> scsi_seq_props.sv
// Port checker for the target-role sequencer.
// Assumes a bind onto the top module and a single core clock domain.
`timescale 1ns/10ps
module scsi_seq_props
  import scsi_target_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire scsi_in_type scsi_i,
  input wire scsi_out_type scsi_o
);
  // **********
  // Properties
  // **********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic cmd_wr;
  logic stop_wr;
  logic load_wr;
  logic aux_rd;
  // Command strobes decoded once
  assign cmd_wr = reg_wr && reg_addr == ADDR_CMD;
  assign stop_wr = cmd_wr && reg_wdata[4:0] == OP_DISCONNECT;
  assign load_wr = cmd_wr && reg_wdata[4:0] >= OP_RESELECT;
  assign aux_rd = reg_rd && reg_addr == ADDR_AUX;

  AST_INT_READ: assert property (reg_rd && reg_addr == ADDR_INT && irq |=> !irq && reg_rdata != 8'h00)
    else $error("interrupt read did not clear irq");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  AST_REQ_BSY: assert property (scsi_o.req |-> scsi_o.bsy)
    else $error("req without bsy");
  AST_PHASE_STEADY: assert property (scsi_o.req ##1 scsi_o.req |-> $stable({scsi_o.msg, scsi_o.cd, scsi_o.io}))
    else $error("phase moved under req");
  AST_REQ_HOLD: assert property (scsi_o.req && !scsi_i.ack |=> scsi_o.req)
    else $error("req dropped before ack");
  AST_REQ_RISE: assert property ($rose(scsi_o.req) |-> !scsi_i.ack)
    else $error("req raised while ack high");
  AST_DMA_HOLD: assert property (dma_req && !dma_ack |=> dma_req)
    else $error("dma_req dropped before ack");
  AST_DMA_DROP: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma_req kept after ack");
  AST_STOP_QUIET: assert property (stop_wr && !irq |=> !irq [*6])
    else $error("disconnect raised irq");
  AST_STOP_FREE: assert property (stop_wr |-> ##[1:8] !scsi_o.bsy)
    else $error("bsy kept after disconnect");
  AST_CMD_FULL: assert property (load_wr ##1 !reg_wr ##1 aux_rd |=> !reg_rdata[AUX_FULL_BIT])
    else $error("full set after command load");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> !irq && !dma_req && !scsi_o.bsy)
    else $error("outputs active after reset");
  COV_SELECT: cover property (scsi_i.sel && !scsi_i.bsy);
  COV_DMA: cover property (dma_req && dma_ack);
  COV_INT_READ: cover property (reg_rd && reg_addr == ADDR_INT && irq);
endmodule : scsi_seq_props

// >>> init_model.sv
// Behavioural SCSI initiator facing the target's pins.
// Assumes the bench resolves the shared data lines and reads the queues.
`timescale 1ns/10ps
module init_model
  import scsi_target_pkg::*;
#(
  parameter logic [2:0] OWN_ID = 3'h7,
  parameter logic [2:0] INIT_ID = 3'h3
) (
  input wire logic core_clk,
  input wire scsi_out_type scsi_o,
  output scsi_in_type bus_i
);
  // **********
  // Initiator
  // **********
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [2:0] phq[$];
  int lag = 0;
  int sel_req = 0;
  int sel_done = 0;
  logic sel_atn = 1'b0;
  logic mute = 1'b0;

  // Selection request; only the loop below drives the pins
  task automatic select(input logic with_atn);
    sel_atn = with_atn;
    sel_req++;
    for (int i = 0; i < 200 && sel_done != sel_req; i++) @(posedge core_clk);
  endtask : select

  // Selection, byte handshake and reselection answer; lag slows the ack
  initial begin
    bus_i = '0;
    forever begin
      @(posedge core_clk);
      bus_i.bsy <= scsi_o.sel && !mute; // mute leaves a reselection unanswered
      if (sel_req != sel_done) begin
        // Bsy left free, held until the target answers
        bus_i.data <= (8'h01 << OWN_ID) | (8'h01 << INIT_ID);
        bus_i.sel <= 1'b1;
        bus_i.atn <= sel_atn;
        for (int i = 0; i < 100 && scsi_o.bsy !== 1'b1; i++) @(posedge core_clk);
        bus_i.sel <= 1'b0;
        bus_i.data <= ~bus_i.data; // released lines must not look valid
        sel_done <= sel_done + 1;
      end else if (scsi_o.req && !bus_i.ack) begin
        phq.push_back({scsi_o.msg, scsi_o.cd, scsi_o.io});
        repeat (lag) @(posedge core_clk);
        if (scsi_o.io) begin
          rxq.push_back(scsi_o.data);
        end else begin
          bus_i.data <= txq.pop_front();
          bus_i.atn <= bus_i.atn && txq.size() > 0; // ATN goes with the last byte
        end
        @(posedge core_clk);
        bus_i.ack <= 1'b1;
        for (int i = 0; i < 200 && scsi_o.req; i++) @(posedge core_clk);
        bus_i.ack <= 1'b0;
        bus_i.data <= ~bus_i.data;
      end
    end
  end
endmodule : init_model

// >>> tb.sv
// Self-checking bench for the target-role sequencer.
// Assumes the checker and initiator model files compile first.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
  import scsi_target_pkg::*;
;
  // **********
  // Harness
  // **********
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dma_wdata, got, exp, nxt;
  logic [7:0] dma_rdata = 8'h55;
  logic reg_wr, reg_rd, irq, dma_req;
  logic dma_ack = 1'b0;
  logic [2:0] ph;
  logic [7:0] dmaq[$];
  logic [4:0] ops[3] = '{OP_RECV_CMD, OP_RECV_DATA, OP_SEND_DATA};
  logic [2:0] phs[3] = '{PH_COMMAND, PH_DATA_OUT, PH_DATA_IN};
  scsi_in_type scsi_i, bus_i;
  scsi_out_type scsi_o, scsi_oe;
  int num_errors = 0;
  int compares = 0;

  scsi_target_role_sequencer u_scsi_target_role_sequencer (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .dma_req, .dma_ack, .dma_rdata, .dma_wdata, .scsi_i, .scsi_o, .scsi_oe);
  init_model u_init_model (.core_clk, .scsi_o, .bus_i);

  // Shared data lines: the driving side wins
  always_comb begin
    scsi_i = bus_i;
    scsi_i.data = (scsi_oe.data & scsi_o.data) | (~scsi_oe.data & bus_i.data);
  end

  // Clock
  initial forever #2 core_clk = ~core_clk;

  // DMA engine answers one cycle late, counts its source bytes
  always @(posedge core_clk) begin
    dma_ack <= dma_req && !dma_ack;
    if (dma_req && dma_ack) begin
      dmaq.push_back(dma_wdata);
      dma_rdata <= dma_rdata + 8'h01;
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk); // Gap edge so a following write never reassigns the strobe
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    rd(a, got);
    `CHK(got, e)
  endtask : chk_rd

  task automatic tc(input logic [23:0] n);
    wr(ADDR_TC_HI, n[23:16]);
    wr(ADDR_TC_MID, n[15:8]);
    wr(ADDR_TC_LO, n[7:0]);
  endtask : tc

  // Spin on the full bit, bounded
  task automatic poll(input logic v);
    for (int i = 0; i < 50; i++) begin
      rd(ADDR_AUX, got);
      if (got[AUX_FULL_BIT] === v) break;
    end
    `CHK(got[AUX_FULL_BIT], v)
  endtask : poll

  task automatic irq_chk(input logic [7:0] e);
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge core_clk);
    chk_rd(ADDR_INT, e);
    `CHK(irq, 1'b0)
  endtask : irq_chk

  task automatic msg_in(input logic [7:0] b);
    wr(ADDR_CMD, {3'b100, OP_SEND_MSG_IN});
    poll(1'b0);
    wr(ADDR_DATA, b);
    irq_chk(INT_FUNC_DONE);
    got = u_init_model.rxq.pop_front();
    `CHK(got, b)
    ph = u_init_model.phq.pop_front();
    `CHK(ph, PH_MSG_IN)
  endtask : msg_in

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Watchdog, many times the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk_rd(ADDR_AUX, 8'h02);
    chk_rd(ADDR_INT, 8'h00);
    chk_rd(ADDR_SRC_ID, 8'h00);
    chk_rd(4'hf, 8'h00);
    wr(ADDR_CMD, {3'b100, OP_SEND_STATUS});
    irq_chk(INT_INVALID);
    u_init_model.select(1'b1);
    irq_chk(8'h0a);
    chk_rd(ADDR_SRC_ID, 8'h83);
    u_init_model.txq.push_back(8'hc0);
    wr(ADDR_CMD, {3'b100, OP_RECV_MSG_OUT});
    poll(1'b1);
    chk_rd(ADDR_DATA, 8'hc0);
    irq_chk(INT_FUNC_DONE);
    ph = u_init_model.phq.pop_front();
    `CHK(ph, PH_MSG_OUT)
    msg_in(8'h02);
    msg_in(8'h04);
    wr(ADDR_CMD, {3'b000, OP_DISCONNECT});
    repeat (8) @(posedge core_clk);
    `CHK(irq, 1'b0)
    `CHK(scsi_o.bsy, 1'b0)
    wr(ADDR_DST_ID, 8'h03);
    tc(24'h000080);
    wr(ADDR_CMD, {3'b000, OP_RESELECT});
    irq_chk(INT_FUNC_DONE);
    msg_in(8'h80);
    // receive command, receive data and send data with DMA, prompt and slow initiator
    for (int i = 0; i < 3; i++) begin
      dmaq.delete();
      nxt = dma_rdata;
      u_init_model.lag = i * 4;
      for (int k = 0; k < 2; k++) begin
        if (phs[i][0] == 1'b0) u_init_model.txq.push_back(8'ha0 + 8'(k));
      end
      tc(24'h000002);
      wr(ADDR_CMD, {3'b010, ops[i]});
      irq_chk(INT_FUNC_DONE);
      for (int k = 0; k < 2; k++) begin
        ph = u_init_model.phq.pop_front();
        `CHK(ph, phs[i])
        got = phs[i][0] ? u_init_model.rxq.pop_front() : dmaq.pop_front();
        exp = phs[i][0] ? nxt + 8'(k) : 8'ha0 + 8'(k);
        `CHK(got, exp)
      end
    end
    wr(ADDR_DATA, 8'haa);
    rd(ADDR_AUX, got);
    `CHK(got[AUX_FULL_BIT], 1'b1)
    wr(ADDR_CMD, {3'b100, OP_SEND_STATUS});
    rd(ADDR_AUX, got);
    `CHK(got[AUX_FULL_BIT], 1'b0)
    wr(ADDR_DATA, 8'h00);
    irq_chk(INT_FUNC_DONE);
    got = u_init_model.rxq.pop_front();
    `CHK(got, 8'h00)
    ph = u_init_model.phq.pop_front();
    `CHK(ph, PH_STATUS)
    msg_in(8'h00);
    wr(ADDR_CMD, {3'b000, OP_DISCONNECT});
    // Unanswered reselection runs out after the counted cycles
    u_init_model.mute = 1'b1;
    tc(24'h000010);
    wr(ADDR_CMD, {3'b000, OP_RESELECT});
    irq_chk(INT_TIMEOUT);
    `CHK(scsi_o.sel, 1'b0)
    test_done();
  end
endmodule : tb

bind scsi_target_role_sequencer scsi_seq_props u_scsi_seq_props (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .irq, .dma_req, .dma_ack, .scsi_i, .scsi_o);
